// file: design/acc_comparator_control.sv
`timescale 1ns/100ps
// Digital control around one analog comparator, reached over APB.
module acc_comparator_control (
  // Clock and reset.
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // APB slave.
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Analog comparator core.
  input  wire logic                          cmp_raw,
  output acc_pkg::acc_analog_ctrl_t          analog_ctrl,
  // Timer 1 prescaled clock and result consumers.
  input  wire logic                          t1_clk_prescaled,
  output acc_pkg::acc_result_out_t           result_out,
  // Port pins.
  input  wire logic [acc_pkg::PORT_W-1:0]    pin_in,
  output logic      [acc_pkg::PORT_W-1:0]    pin_out,
  output logic      [acc_pkg::PORT_W-1:0]    pin_oe,
  // Processor interrupt request.
  output logic                               cmp_irq
);

  // Writable control state.
  logic [7:0]                 control_a;      // Enable, pin, polarity, speed, hysteresis, sync.
  logic [7:0]                 control_b;      // Edge enables and input selects.
  logic [2:0]                 irq_en;         // Comparator, peripheral and global enables.
  logic [acc_pkg::PORT_W-1:0] port_latch;     // Port data latch.
  logic [acc_pkg::PORT_W-1:0] pin_direction;  // One means input.
  logic [acc_pkg::PORT_W-1:0] analog_select;  // One means analog input.

  // Comparator result path.
  logic cmp_result;       // Registered polarity-corrected result.
  logic cmp_result_prev;  // Previous result for edge detection.
  logic sync_capture;     // Result captured on timer clock falling edge.
  logic t1_clk_prev;      // Previous synchronised timer clock.
  logic cmp_irq_flag;     // Sticky interrupt flag.
  logic [7:0] settle_cnt; // Remaining response interval cycles.
  logic [31:0] next_prdata;

  // Synchronised views of asynchronous inputs.
  logic [acc_pkg::PORT_W+1:0] sync_bus;
  logic                       raw_s;
  logic                       t1_clk_s;
  logic [acc_pkg::PORT_W-1:0] pin_s;

  // Named control fields.
  wire cmp_enable            = control_a[acc_pkg::CA_ENABLE];
  wire cmp_pin_output_enable = control_a[acc_pkg::CA_PIN_OE];
  wire cmp_invert            = control_a[acc_pkg::CA_INVERT];
  wire cmp_speed_select      = control_a[acc_pkg::CA_SPEED];
  wire cmp_hysteresis_enable = control_a[acc_pkg::CA_HYST];
  wire cmp_sync_to_timer     = control_a[acc_pkg::CA_SYNC];

  // Edge enables and selects.
  wire cmp_rise_irq_enable   = control_b[acc_pkg::CB_RISE_EN];
  wire cmp_fall_irq_enable   = control_b[acc_pkg::CB_FALL_EN];
  wire [1:0] pos_input_select = control_b[acc_pkg::CB_POS_LO +: 2];
  wire neg_input_select      = control_b[acc_pkg::CB_NEG_SEL];

  // Interrupt enable chain.
  wire cmp_irq_enable        = irq_en[acc_pkg::IEN_CMP];
  wire peripheral_irq_enable = irq_en[acc_pkg::IEN_PERIPH];
  wire global_irq_enable     = irq_en[acc_pkg::IEN_GLOBAL];

  // Bring the comparator, timer clock and pins into this domain.
  acc_sync2 #(
    .WIDTH (acc_pkg::PORT_W + 2)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({pin_in, t1_clk_prescaled, cmp_raw}),
    .sync_out (sync_bus)
  );
  assign raw_s    = sync_bus[0];
  assign t1_clk_s = sync_bus[1];
  assign pin_s    = sync_bus[acc_pkg::PORT_W+1:2];

  // APB decode; every access completes with no wait state.
  wire setup_ph  = psel && !penable;
  wire access_ph = psel && penable;
  wire wr_en     = access_ph && pwrite;
  wire wr_ctl_a  = wr_en && (paddr == acc_pkg::ADDR_CONTROL_A);
  wire wr_ctl_b  = wr_en && (paddr == acc_pkg::ADDR_CONTROL_B);
  wire wr_flag   = wr_en && (paddr == acc_pkg::ADDR_FLAG);
  wire wr_irq_en = wr_en && (paddr == acc_pkg::ADDR_IRQ_EN);
  wire wr_lat    = wr_en && (paddr == acc_pkg::ADDR_PORT_LAT);
  wire wr_dir    = wr_en && (paddr == acc_pkg::ADDR_PORT_DIR);
  wire wr_ana    = wr_en && (paddr == acc_pkg::ADDR_PORT_ANA);

  // Reports whether an address names one of the registers.
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == acc_pkg::ADDR_CONTROL_A) || (a == acc_pkg::ADDR_CONTROL_B) ||
                  (a == acc_pkg::ADDR_OUTPUT)    || (a == acc_pkg::ADDR_FLAG)      ||
                  (a == acc_pkg::ADDR_IRQ_EN)    || (a == acc_pkg::ADDR_PORT_LAT)  ||
                  (a == acc_pkg::ADDR_PORT_DIR)  || (a == acc_pkg::ADDR_PORT_ANA)  ||
                  (a == acc_pkg::ADDR_PORT_READ);
  endfunction

  assign pready  = 1'b1;
  assign pslverr = access_ph && !addr_mapped(paddr);

  // Result of the compare before the cycle register. A disabled comparator gives a
  // low core level, so polarity or enable toggles still produce edges.
  wire next_result = (cmp_enable & raw_s) ^ cmp_invert; // RULE_05 RULE_15 RULE_25

  // Edges of the registered result and the flag clear request.
  wire rise_edge  = cmp_result & ~cmp_result_prev; // RULE_12
  wire fall_edge  = ~cmp_result & cmp_result_prev; // RULE_12
  wire edge_hit   = (rise_edge & cmp_rise_irq_enable) | (fall_edge & cmp_fall_irq_enable);
  wire flag_clear = wr_flag && pwdata[acc_pkg::FLAG_CMP];
  wire t1_fall    = t1_clk_prev & ~t1_clk_s; // RULE_10 RULE_11

  // External result: latched on the timer clock falling edge only in sync mode.
  wire ext_result = cmp_sync_to_timer ? sync_capture : cmp_result; // RULE_04 RULE_10

  // Any change of selection, enable or hysteresis restarts the response interval.
  wire sel_change = (wr_ctl_b && (pwdata[5:0] != control_b[5:0] ||
                                  pwdata[7:6] != control_b[7:6])) ||
                    (wr_ctl_a && (pwdata[acc_pkg::CA_ENABLE] != cmp_enable ||
                                  pwdata[acc_pkg::CA_HYST] != cmp_hysteresis_enable));

  // Register file writes; reserved bits stay zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      control_a     <= acc_pkg::RST_CONTROL_A; // RULE_06
      control_b     <= acc_pkg::RST_CONTROL_B;
      irq_en        <= 3'h0;
      port_latch    <= acc_pkg::RST_PORT_LAT;
      pin_direction <= acc_pkg::RST_PORT_DIR;
      analog_select <= acc_pkg::RST_PORT_ANA;
    end else begin
      if (wr_ctl_a) begin
        control_a <= pwdata[7:0] & 8'hb7;
      end
      if (wr_ctl_b) begin
        control_b <= pwdata[7:0] & 8'hf1;
      end
      if (wr_irq_en) begin
        irq_en <= pwdata[2:0];
      end
      if (wr_lat) begin
        port_latch <= pwdata[acc_pkg::PORT_W-1:0];
      end
      if (wr_dir) begin
        pin_direction <= pwdata[acc_pkg::PORT_W-1:0];
      end
      if (wr_ana) begin
        analog_select <= pwdata[acc_pkg::PORT_W-1:0];
      end
    end
  end

  // Result registered once per instruction cycle, plus edge history.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmp_result      <= 1'b0;
      cmp_result_prev <= 1'b0;
    end else begin
      cmp_result      <= next_result; // RULE_04
      cmp_result_prev <= cmp_result;
    end
  end

  // Timer clock edge capture; the falling edge latches so timer counting on
  // the rising edge never races with a changing result.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      t1_clk_prev  <= 1'b0;
      sync_capture <= 1'b0;
    end else begin
      t1_clk_prev <= t1_clk_s;
      if (t1_fall) begin
        sync_capture <= cmp_result; // RULE_10 RULE_11
      end
    end
  end

  // Sticky flag: an edge in the clearing cycle wins over the clear.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmp_irq_flag <= 1'b0;
    end else if (edge_hit) begin
      cmp_irq_flag <= 1'b1; // RULE_12 RULE_13
    end else if (flag_clear) begin
      // Cleared only by a software write.
      cmp_irq_flag <= 1'b0; // RULE_13
    end
  end

  // Response interval counter; software sees it as a settling status bit.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      settle_cnt <= 8'h00;
    end else if (sel_change) begin
      settle_cnt <= 8'(acc_pkg::RESPONSE_CYCLES); // RULE_19
    end else if (settle_cnt != 8'h00) begin
      // Count down, then hold at zero.
      settle_cnt <= settle_cnt - 8'h01;
    end
  end

  // Read data is fetched in the setup phase so it stands during access.
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      acc_pkg::ADDR_CONTROL_A: begin
        next_prdata[7:0] = control_a;
        next_prdata[acc_pkg::CA_RESULT] = cmp_result; // RULE_01
      end
      acc_pkg::ADDR_CONTROL_B: next_prdata[7:0] = control_b;
      acc_pkg::ADDR_OUTPUT: begin
        next_prdata[acc_pkg::OUT_MIRROR] = cmp_result; // RULE_01
        next_prdata[acc_pkg::OUT_SETTLE] = (settle_cnt != 8'h00); // RULE_19
      end
      acc_pkg::ADDR_FLAG:      next_prdata[acc_pkg::FLAG_CMP] = cmp_irq_flag;
      acc_pkg::ADDR_IRQ_EN:    next_prdata[2:0] = irq_en;
      acc_pkg::ADDR_PORT_LAT:  next_prdata[acc_pkg::PORT_W-1:0] = port_latch;
      acc_pkg::ADDR_PORT_DIR:  next_prdata[acc_pkg::PORT_W-1:0] = pin_direction;
      acc_pkg::ADDR_PORT_ANA:  next_prdata[acc_pkg::PORT_W-1:0] = analog_select;
      acc_pkg::ADDR_PORT_READ: next_prdata[acc_pkg::PORT_W-1:0] = pin_s & ~analog_select; // RULE_22
      default:                 next_prdata = 32'h0000_0000;
    endcase
  end

  // Read data register.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Analog core controls; a disabled comparator has every input cut off.
  assign analog_ctrl.connect           = cmp_enable; // RULE_17 RULE_25
  assign analog_ctrl.pos_input_select  = pos_input_select; // RULE_16 RULE_23 RULE_26
  assign analog_ctrl.neg_input_select  = neg_input_select; // RULE_18 RULE_24
  assign analog_ctrl.speed_select      = cmp_speed_select; // RULE_06
  assign analog_ctrl.hysteresis_enable = cmp_hysteresis_enable; // RULE_07

  // Results for the timer gate and PWM shutdown.
  assign result_out.timer_gate   = ext_result; // RULE_08 RULE_10
  assign result_out.pwm_shutdown = cmp_result; // RULE_21

  // Port drivers: the comparator pin swaps in the result when its output enable is
  // set; in that mode its driver only turns on with the comparator enabled.
  genvar gi;
  generate
    for (gi = 0; gi < acc_pkg::PORT_W; gi++) begin : g_pin
      if (gi == acc_pkg::CMP_PIN_IDX) begin : g_cmp
        assign pin_out[gi] = cmp_pin_output_enable ? ext_result : port_latch[gi]; // RULE_03
        assign pin_oe[gi]  = !pin_direction[gi] &&
                             (!cmp_pin_output_enable || cmp_enable); // RULE_02
      end else begin : g_plain
        // Other pins follow latch and direction.
        assign pin_out[gi] = port_latch[gi];
        assign pin_oe[gi]  = !pin_direction[gi];
      end
    end
  endgenerate

  // Interrupt request needs every enable in the chain.
  assign cmp_irq = cmp_irq_flag && cmp_enable && cmp_irq_enable && peripheral_irq_enable &&
                   global_irq_enable && (cmp_rise_irq_enable || cmp_fall_irq_enable); // RULE_14

  // Checks on the block's outputs and internal state.
  AST_MIRROR_READ: assert property (@(posedge clk_sys) disable iff (rst) // RULE_01
    (setup_ph && !pwrite && paddr == acc_pkg::ADDR_OUTPUT)
      |=> prdata[acc_pkg::OUT_MIRROR] == $past(cmp_result))
    else $error("Mirror read does not show the result.");

  AST_PIN_DRIVE: assert property (@(posedge clk_sys) disable iff (rst) // RULE_02
    (cmp_pin_output_enable && pin_oe[acc_pkg::CMP_PIN_IDX])
      |-> (cmp_enable && !pin_direction[acc_pkg::CMP_PIN_IDX]))
    else $error("Comparator pin driven without all conditions.");

  AST_PIN_OVERRIDE: assert property (@(posedge clk_sys) disable iff (rst) // RULE_03
    cmp_pin_output_enable |-> pin_out[acc_pkg::CMP_PIN_IDX] == ext_result)
    else $error("Comparator pin not overriding latch.");

  AST_POLARITY: assert property (@(posedge clk_sys) disable iff (rst) // RULE_05
    ##1 cmp_result == ($past(cmp_enable & raw_s) ^ $past(cmp_invert)))
    else $error("Result polarity wrong.");

  AST_SYNC_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // RULE_10
    (cmp_sync_to_timer && !t1_fall) ##1 cmp_sync_to_timer |-> $stable(result_out.timer_gate))
    else $error("Synchronised result changed without timer falling edge.");

  AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (rst) // RULE_12
    edge_hit |=> cmp_irq_flag)
    else $error("Enabled edge did not set flag.");

  AST_FLAG_STICKY: assert property (@(posedge clk_sys) disable iff (rst) // RULE_13
    (cmp_irq_flag && !flag_clear) |=> cmp_irq_flag)
    else $error("Flag dropped without software clear.");

  AST_IRQ_GATE: assert property (@(posedge clk_sys) disable iff (rst) // RULE_14
    cmp_irq |-> (cmp_irq_flag && cmp_enable && global_irq_enable && peripheral_irq_enable))
    else $error("Interrupt raised with an enable clear.");

  AST_DISCONNECT: assert property (@(posedge clk_sys) disable iff (rst) // RULE_17
    $fell(cmp_enable) |-> !analog_ctrl.connect ##1 settle_cnt != 8'h00)
    else $error("Disabled comparator left inputs connected.");

  AST_PORT_ANALOG: assert property (@(posedge clk_sys) disable iff (rst) // RULE_22
    (setup_ph && !pwrite && paddr == acc_pkg::ADDR_PORT_READ)
      |=> (prdata[acc_pkg::PORT_W-1:0] & $past(analog_select)) == '0)
    else $error("Analog pin read as nonzero.");

  AST_SETTLE_START: assert property (@(posedge clk_sys) disable iff (rst) // RULE_19
    sel_change |=> settle_cnt == 8'(acc_pkg::RESPONSE_CYCLES))
    else $error("Response interval did not restart.");

  // Main scenarios worth seeing.
  COV_RISE_FLAG: cover property (@(posedge clk_sys) disable iff (rst)
    rise_edge && cmp_rise_irq_enable ##1 cmp_irq);
  COV_SET_WINS: cover property (@(posedge clk_sys) disable iff (rst)
    edge_hit && flag_clear);
  COV_SYNC_CAPTURE: cover property (@(posedge clk_sys) disable iff (rst)
    cmp_sync_to_timer && t1_fall ##1 $changed(sync_capture));
  COV_SETTLE: cover property (@(posedge clk_sys) disable iff (rst)
    sel_change ##1 settle_cnt != 8'h00);

endmodule // acc_comparator_control

// file: design/acc_pkg.sv
// Notes on behaviour
// RULE_01 - Result readable in control and mirror register
// RULE_02 - Pin driven needs output enable, direction, enable
// RULE_03 - Output enable overrides port latch, ignores enable
// RULE_04 - Internal result registered each cycle
// RULE_05 - Result high when positive input exceeds; polarity inverts
// RULE_06 - Speed select resets to one, normal speed
// RULE_07 - Hysteresis applied only while its bit set
// RULE_08 - Result offered as timer-1 gate source
// RULE_09 - Software should enable timer synchronisation
// RULE_10 - Sync mode captures on timer-1 clock falling edge
// RULE_11 - Sync capture uses the prescaled timer clock
// RULE_12 - Rising and falling edges set flag when enabled
// RULE_13 - Flag cleared by software only; set wins
// RULE_14 - Interrupt needs enable and all interrupt enables
// RULE_15 - Polarity or enable toggles can set flag
// RULE_16 - Two-bit select routes four positive sources
// RULE_17 - Disabled comparator disconnects all inputs
// RULE_18 - One bit selects between two negative pins
// RULE_19 - Output indeterminate for response time after changes
// RULE_20 - Software checks output after first initialisation
// RULE_21 - Result feeds PWM auto-shutdown logic
// RULE_22 - Port reads return zero for analog pins
// RULE_23 - Codes 10 reference, 01 DAC, 00 pin
// RULE_24 - Negative select one picks second pin
// RULE_25 - Enable bit starts comparator; clear saves power
// RULE_26 - Positive select code 11 selects ground
package acc_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [7:0] ADDR_CONTROL_A = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_B = 8'h04;
  localparam logic [7:0] ADDR_OUTPUT    = 8'h08;
  localparam logic [7:0] ADDR_FLAG      = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h10;
  localparam logic [7:0] ADDR_PORT_LAT  = 8'h14;
  localparam logic [7:0] ADDR_PORT_DIR  = 8'h18;
  localparam logic [7:0] ADDR_PORT_ANA  = 8'h1c;
  localparam logic [7:0] ADDR_PORT_READ = 8'h20;

  // Field positions of control register A.
  localparam int CA_ENABLE = 7;
  localparam int CA_RESULT = 6;
  localparam int CA_PIN_OE = 5;
  localparam int CA_INVERT = 4;
  localparam int CA_SPEED  = 2;
  localparam int CA_HYST   = 1;
  localparam int CA_SYNC   = 0;

  // Field positions of control register B.
  localparam int CB_RISE_EN = 7;
  localparam int CB_FALL_EN = 6;
  localparam int CB_POS_LO  = 4;
  localparam int CB_NEG_SEL = 0;

  // Field positions of the output, flag and enable registers.
  localparam int OUT_MIRROR  = 0;
  localparam int OUT_SETTLE  = 1;
  localparam int FLAG_CMP    = 0;
  localparam int IEN_CMP     = 0;
  localparam int IEN_PERIPH  = 1;
  localparam int IEN_GLOBAL  = 2;

  // Reset values of the writable registers.
  localparam logic [7:0] RST_CONTROL_A = 8'h04;
  localparam logic [7:0] RST_CONTROL_B = 8'h00;
  localparam logic [5:0] RST_PORT_LAT  = 6'h00;
  localparam logic [5:0] RST_PORT_DIR  = 6'h3f;
  localparam logic [5:0] RST_PORT_ANA  = 6'h3f;

  // Port geometry and the pin that carries the comparator output.
  localparam int PORT_W      = 6;
  localparam int CMP_PIN_IDX = 2;

  // Positive input select codes.
  localparam logic [1:0] POS_PIN    = 2'h0;
  localparam logic [1:0] POS_DAC    = 2'h1;
  localparam logic [1:0] POS_FIXED  = 2'h2;
  localparam logic [1:0] POS_GROUND = 2'h3;

  // Response interval after any input or reference change.
  localparam int CLK_PERIOD_NS    = 50;
  localparam int RESPONSE_TIME_NS = 1000;
  localparam int RESPONSE_CYCLES  = (RESPONSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Controls handed to the analog comparator core.
  typedef struct packed {
    logic       connect;
    logic [1:0] pos_input_select;
    logic       neg_input_select;
    logic       speed_select;
    logic       hysteresis_enable;
  } acc_analog_ctrl_t;

  // Digital result outputs towards timer 1 and the PWM unit.
  typedef struct packed {
    logic timer_gate;
    logic pwm_shutdown;
  } acc_result_out_t;

endpackage

// file: design/acc_sync2.sv
`timescale 1ns/100ps
// Two-flop synchroniser for levels arriving from outside the clock domain.
module acc_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Asynchronous level in, synchronised level out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // First stage; only the second stage reads it.
  logic [WIDTH-1:0] stage_one;

  // Both stages clear on reset so no metastable level leaks out early.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule // acc_sync2

// file: tb/acc_far_side.sv
`timescale 1ns/100ps
// Behavioural far side: comparator core level, timer-1 prescaled clock and port wires.
module acc_far_side (
  // Clock.
  input  wire logic                       clk_sys,
  // Scenario controls set by the bench.
  input  wire logic                       core_level,
  input  wire logic                       t1_run,
  // Device side.
  input  wire acc_pkg::acc_analog_ctrl_t  analog_ctrl,
  input  wire logic [acc_pkg::PORT_W-1:0] pin_out,
  input  wire logic [acc_pkg::PORT_W-1:0] pin_oe,
  output logic                            cmp_raw,
  output logic                            t1_clk_prescaled,
  output logic [acc_pkg::PORT_W-1:0]      pin_in
);
  logic [1:0] t1_div;    // Divides the system clock down to the timer clock.
  logic       float_bit; // Flips every cycle to stand for a line nobody drives.

  // Start with the timer clock standing high.
  initial begin
    t1_div = 2'h0;
    float_bit = 1'b0;
    t1_clk_prescaled = 1'b1;
  end

  // The timer clock only stops at its high level, so no stray falling edge appears.
  always @(posedge clk_sys) begin
    float_bit <= ~float_bit;
    t1_div <= t1_div + 2'h1;
    if ((t1_run || !t1_clk_prescaled) && t1_div == 2'h3) begin
      t1_clk_prescaled <= ~t1_clk_prescaled;
    end
  end

  // A connected core reports positive above negative; a disconnected one wanders.
  assign cmp_raw = analog_ctrl.connect ? core_level : float_bit;

  // Each pin shows its driver; an undriven pin wanders, since no pull exists.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & {acc_pkg::PORT_W{float_bit}});
endmodule // acc_far_side

// file: tb/analog_comparator_control_tb.sv
`timescale 1ns/100ps
// Self-checking bench: APB stimulus, a queue of expected reads and direct port checks.
module analog_comparator_control_tb;
  logic                            clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]                      paddr;
  logic [31:0]                     pwdata, prdata, seed;
  logic                            cmp_raw, t1_clk_prescaled, cmp_irq, core_level, t1_run;
  logic [acc_pkg::PORT_W-1:0]      pin_in, pin_out, pin_oe, latch;
  acc_pkg::acc_analog_ctrl_t       analog_ctrl;
  acc_pkg::acc_result_out_t        result_out;
  logic [64:0]                     exp_q[$]; // Pending reads: error, mask, value.
  logic [64:0]                     e;        // Note taken off the queue.
  int                              n_errors, checked, cycles;

  acc_comparator_control dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_raw(cmp_raw), .analog_ctrl(analog_ctrl),
    .t1_clk_prescaled(t1_clk_prescaled), .result_out(result_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .cmp_irq(cmp_irq));
  acc_far_side far_u (.clk_sys(clk_sys), .core_level(core_level), .t1_run(t1_run),
    .analog_ctrl(analog_ctrl), .pin_out(pin_out), .pin_oe(pin_oe), .cmp_raw(cmp_raw),
    .t1_clk_prescaled(t1_clk_prescaled), .pin_in(pin_in));

  // Free-running 20 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Xorshift source for random port data, from a fixed seed.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Notes the expected answer, then reads; the watcher compares.
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
                    input logic err = 1'b0);
    exp_q.push_back({err, m, x});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] x);
    checked++;
    if (got !== x) begin
      n_errors++;
      $display("[FAIL] %0t port value %h, expected %h", $time, got, x);
    end
  endtask

  // Watches every read access and compares it with the oldest note.
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready) begin
      checked++;
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("[FAIL] %0t read with no expectation", $time);
      end else begin
        e = exp_q.pop_front();
        if (((prdata & e[63:32]) !== e[31:0]) || (pslverr !== e[64])) begin
          n_errors++;
          $display("[FAIL] %0t read %h err %b, expected %h", $time, prdata, pslverr, e[31:0]);
        end
      end
    end
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // Main sequence.
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {core_level, t1_run, n_errors, checked, cycles} = '0;
    seed = 32'h9c92;
    rst = 1'b1;
    waitc(8);
    rst <= 1'b0;
    // Reset values, and an unmapped address that must be refused.
    rd(acc_pkg::ADDR_CONTROL_A, 32'h4, 32'hffffffbf);
    rd(acc_pkg::ADDR_CONTROL_B, 32'h0, 32'hffffffff);
    rd(acc_pkg::ADDR_PORT_DIR, 32'h3f, 32'hffffffff);
    rd(8'h3c, 32'h0, 32'hffffffff, 1'b1);
    chk({analog_ctrl.connect, analog_ctrl.speed_select}, 32'h1);
    $display("reset test done");
    // Result through both registers, then inverted; consumers follow it.
    core_level <= 1'b1;
    wr(acc_pkg::ADDR_CONTROL_A, 32'h84);
    waitc(8);
    rd(acc_pkg::ADDR_CONTROL_A, 32'hc4, 32'hff);
    rd(acc_pkg::ADDR_OUTPUT, 32'h1, 32'h1);
    chk({result_out.timer_gate, result_out.pwm_shutdown}, 32'h3);
    wr(acc_pkg::ADDR_CONTROL_A, 32'h94);
    waitc(8);
    rd(acc_pkg::ADDR_CONTROL_A, 32'h94, 32'hff);
    $display("result test done");
    // Edge flag, interrupt gating and clearing.
    wr(acc_pkg::ADDR_IRQ_EN, 32'h7);
    wr(acc_pkg::ADDR_CONTROL_B, 32'h80);
    wr(acc_pkg::ADDR_CONTROL_A, 32'h84);
    waitc(8);
    rd(acc_pkg::ADDR_FLAG, 32'h1, 32'h1);
    chk(cmp_irq, 32'h1);
    wr(acc_pkg::ADDR_FLAG, 32'h1);
    rd(acc_pkg::ADDR_FLAG, 32'h0, 32'h1);
    wr(acc_pkg::ADDR_IRQ_EN, 32'h3);
    wr(acc_pkg::ADDR_CONTROL_A, 32'h94);
    waitc(8);
    rd(acc_pkg::ADDR_FLAG, 32'h0, 32'h1);
    wr(acc_pkg::ADDR_CONTROL_B, 32'hc0);
    wr(acc_pkg::ADDR_CONTROL_A, 32'h84);
    waitc(8);
    rd(acc_pkg::ADDR_FLAG, 32'h1, 32'h1);
    chk(cmp_irq, 32'h0);
    // A disabled comparator still flags an edge made by the polarity bit.
    wr(acc_pkg::ADDR_CONTROL_A, 32'h04);
    waitc(8);
    wr(acc_pkg::ADDR_FLAG, 32'h1);
    rd(acc_pkg::ADDR_FLAG, 32'h0, 32'h1);
    wr(acc_pkg::ADDR_CONTROL_A, 32'h14);
    waitc(8);
    rd(acc_pkg::ADDR_FLAG, 32'h1, 32'h1);
    $display("interrupt test done");
    // Every input select code, then the settling indication.
    for (int i = 0; i < 4; i++) begin
      wr(acc_pkg::ADDR_CONTROL_B, (i << acc_pkg::CB_POS_LO) | (i & 1));
      waitc(1);
      chk(analog_ctrl.pos_input_select, i);
      chk(analog_ctrl.neg_input_select, i & 1);
    end
    rd(acc_pkg::ADDR_OUTPUT, 32'h2, 32'h2);
    waitc(25);
    rd(acc_pkg::ADDR_OUTPUT, 32'h0, 32'h2);
    wr(acc_pkg::ADDR_CONTROL_A, 32'h82);
    waitc(1);
    chk({analog_ctrl.hysteresis_enable, analog_ctrl.speed_select}, 32'h2);
    $display("select test done");
    // Pin drive and override, then analog pins reading zero.
    latch = 6'(xs());
    wr(acc_pkg::ADDR_CONTROL_A, 32'ha4);
    wr(acc_pkg::ADDR_PORT_LAT, latch);
    wr(acc_pkg::ADDR_PORT_DIR, 32'h0);
    wr(acc_pkg::ADDR_PORT_ANA, 32'h0);
    waitc(8);
    chk(pin_oe, 32'h3f);
    chk(pin_out, (latch & 6'h3b) | 6'h04);
    rd(acc_pkg::ADDR_PORT_READ, (latch & 6'h3b) | 6'h04, 32'hffffffff);
    wr(acc_pkg::ADDR_PORT_ANA, 32'h3f);
    rd(acc_pkg::ADDR_PORT_READ, 32'h0, 32'hffffffff);
    wr(acc_pkg::ADDR_CONTROL_A, 32'h24);
    waitc(8);
    chk(pin_oe[acc_pkg::CMP_PIN_IDX], 32'h0);
    chk(pin_out[acc_pkg::CMP_PIN_IDX], 32'h0);
    $display("pin test done");
    // Synchronised gate output holds until the timer clock falls.
    wr(acc_pkg::ADDR_CONTROL_A, 32'h85);
    t1_run <= 1'b1;
    waitc(20);
    t1_run <= 1'b0;
    waitc(12);
    chk(result_out.timer_gate, 32'h1);
    core_level <= 1'b0;
    waitc(8);
    chk(result_out.pwm_shutdown, 32'h0);
    chk(result_out.timer_gate, 32'h1);
    t1_run <= 1'b1;
    waitc(16);
    chk(result_out.timer_gate, 32'h0);
    $display("sync test done");
    report_and_stop();
  end
endmodule // analog_comparator_control_tb
